// ### hdl/prom_readout_pkg.sv
// Purpose: Shared constants and carriers for the serial configuration store readout
// Assumes: Core clock of 200 MHz
// Notes:   Power-up hold is kept as a time and derived into cycles
package prom_readout_pkg;

    localparam int CORE_CLK_HZ     = 200_000_000;
    localparam int POR_TIME_MS     = 1;
    localparam int POR_CYCLES      = POR_TIME_MS * (CORE_CLK_HZ / 1000);

    localparam int DATA_W_DEF      = 1;
    localparam int DEPTH_DEF       = 256;

    localparam logic RST_PAST      = 1'b0;
    localparam logic RST_OE_N      = 1'b1;
    localparam logic RST_CHAIN_N   = 1'b1;
    localparam logic RST_POR_DONE  = 1'b0;
    localparam logic RST_CLK_PREV  = 1'b0;

    // Pin-side controls that leave the block together
    typedef struct packed {
        logic data_oe_n;
        logic chain_n;
        logic oer_oe_n;
    } pin_ctl_s;

    localparam pin_ctl_s PIN_CTL_RST = '{data_oe_n: 1'b1, chain_n: 1'b1, oer_oe_n: 1'b0};

endpackage

// ### hdl/prom_store.sv
// Purpose: Stored configuration words with a load port and registered read
// Assumes: Load and read never target the same word in one cycle
// Notes:   Read data follows the requested address by one clock
`timescale 1ns/10ps
module prom_store #(
    parameter int DATA_W = prom_readout_pkg::DATA_W_DEF,
    parameter int DEPTH  = prom_readout_pkg::DEPTH_DEF,
    parameter int ADDR_W = $clog2(DEPTH)
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              load_en,
    input  wire logic [ADDR_W-1:0] load_addr,
    input  wire logic [DATA_W-1:0] load_data,
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic      [DATA_W-1:0] rd_data
);

    logic [DATA_W-1:0] mem [DEPTH];
    logic [DATA_W-1:0] rd_data_d;

    if (DEPTH < 2 || DATA_W < 1 || ADDR_W != $clog2(DEPTH)) begin : g_bad_geometry
        $error("prom_store: unsupported geometry");
    end

    always_comb begin
        rd_data_d = mem[rd_addr];
    end

    // Array left without reset so it maps onto plain storage
    always_ff @(posedge clk) begin
        if (load_en) begin
            mem[load_addr] <= load_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else begin
            rd_data <= rd_data_d;
        end
    end

endmodule

// ### hdl/prom_readout.sv
// Purpose: Readout control of a cascadable serial configuration store
// Assumes: All pins synchronous to CORE_CLK; config_clock is a sampled level
// Notes:   Data pin and reset line are split into value and enable
// Notes on behaviour
// - Edge after last item: chain low, data floats.
// - Low enable in means drive data line.
// - Reset line low or enable high: hold reset.
// - Hold reset line low about 1 ms after power-up.
// - Enable high: standby, address counter reset.
// - Standby keeps data floating whatever reset line says.
// - Count to last address, then hold, float, chain low.
// - Last address highest; one beyond means zero.
// - Advance on each config_clock rising edge.
`timescale 1ns/10ps
module prom_readout #(
    parameter int DATA_W     = prom_readout_pkg::DATA_W_DEF,
    parameter int DEPTH      = prom_readout_pkg::DEPTH_DEF,
    parameter int POR_CYCLES = prom_readout_pkg::POR_CYCLES,
    parameter int ADDR_W     = $clog2(DEPTH),
    parameter int POR_W      = $clog2(POR_CYCLES + 1)
) (
    input  wire logic              CORE_CLK,
    input  wire logic              RST_N,
    input  wire logic              CONFIG_CLOCK,
    input  wire logic              CHIP_ENABLE_IN_N,
    input  wire logic              OE_RESET_IN,
    output logic                   OE_RESET_OUT,
    output logic                   OE_RESET_OE_N,
    output logic      [DATA_W-1:0] DATA_OUT,
    output logic                   DATA_OE_N,
    output logic                   CHAIN_ENABLE_OUT_N,
    input  wire logic              LOAD_EN,
    input  wire logic [ADDR_W-1:0] LOAD_ADDR,
    input  wire logic [DATA_W-1:0] LOAD_DATA
);

    localparam logic [ADDR_W-1:0] LAST_ADDRESS = ADDR_W'(DEPTH - 1);
    localparam logic [POR_W-1:0]  POR_LAST     = POR_W'(POR_CYCLES - 1);

    if (DEPTH < 2 || POR_CYCLES < 1 || DATA_W < 1) begin : g_bad_geometry
        $error("prom_readout: unsupported parameters");
    end
    // Widths are derived; a narrower override would wrap the counters early
    if (ADDR_W != $clog2(DEPTH) || POR_W < $clog2(POR_CYCLES + 1)) begin : g_bad_widths
        $error("prom_readout: counter widths do not fit");
    end

    logic                        clk_prev_q, clk_prev_d;
    logic                        cfg_rise;
    logic                        active;
    logic [ADDR_W-1:0]           addr_q, addr_d;
    logic                        past_q, past_d;
    logic [POR_W-1:0]            por_cnt_q, por_cnt_d;
    logic                        por_done_q, por_done_d;
    prom_readout_pkg::pin_ctl_s  ctl_q, ctl_d;

    // Power-up hold of the shared reset line
    always_comb begin
        por_cnt_d  = por_cnt_q;
        por_done_d = por_done_q;
        if (!por_done_q) begin
            if (por_cnt_q == POR_LAST) begin
                por_done_d = 1'b1;
            end else begin
                por_cnt_d = por_cnt_q + POR_W'(1);
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            por_cnt_q  <= '0;
            por_done_q <= prom_readout_pkg::RST_POR_DONE;
        end else begin
            por_cnt_q  <= por_cnt_d;
            por_done_q <= por_done_d;
        end
    end

    // Read while reset line is low or enable is high gives the idle state
    assign active   = por_done_q && OE_RESET_IN && !CHIP_ENABLE_IN_N;
    assign cfg_rise = CONFIG_CLOCK && !clk_prev_q;

    // Address counter and end-of-data flag
    always_comb begin
        clk_prev_d = CONFIG_CLOCK;
        addr_d     = addr_q;
        past_d     = past_q;
        if (!active) begin
            addr_d = '0;
            past_d = 1'b0;
        end else if (cfg_rise && !past_q) begin
            if (addr_q == LAST_ADDRESS) begin
                addr_d = '0;
                past_d = 1'b1;
            end else begin
                addr_d = addr_q + ADDR_W'(1);
            end
        end
    end

    // Pin controls follow the next counter and power-up state so they change with them
    always_comb begin
        ctl_d.data_oe_n = !(active && !past_d);
        ctl_d.chain_n   = !(active && past_d);
        ctl_d.oer_oe_n  = por_done_d;
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            clk_prev_q <= prom_readout_pkg::RST_CLK_PREV;
            addr_q     <= '0;
            past_q     <= prom_readout_pkg::RST_PAST;
            ctl_q      <= prom_readout_pkg::PIN_CTL_RST;
        end else begin
            clk_prev_q <= clk_prev_d;
            addr_q     <= addr_d;
            past_q     <= past_d;
            ctl_q      <= ctl_d;
        end
    end

    // Value flop tied low; the line only ever sinks
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            OE_RESET_OUT <= 1'b0;
        end else begin
            OE_RESET_OUT <= 1'b0;
        end
    end

    assign OE_RESET_OE_N      = ctl_q.oer_oe_n;
    assign DATA_OE_N          = ctl_q.data_oe_n;
    assign CHAIN_ENABLE_OUT_N = ctl_q.chain_n;

    prom_store #(
        .DATA_W (DATA_W),
        .DEPTH  (DEPTH),
        .ADDR_W (ADDR_W)
    ) u_store (
        .clk       (CORE_CLK),
        .rst_n     (RST_N),
        .load_en   (LOAD_EN),
        .load_addr (LOAD_ADDR),
        .load_data (LOAD_DATA),
        .rd_addr   (addr_d),
        .rd_data   (DATA_OUT)
    );

    // Hold length counted apart from the release logic, for the checks only
    logic [POR_W-1:0]            hold_seen_q, hold_seen_d;

    always_comb begin
        hold_seen_d = hold_seen_q;
        if (!OE_RESET_OE_N && hold_seen_q != POR_W'(POR_CYCLES)) begin
            hold_seen_d = hold_seen_q + POR_W'(1);
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            hold_seen_q <= '0;
        end else begin
            hold_seen_q <= hold_seen_d;
        end
    end

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RST_N);

    idle_tristate_a: assert property (!active |=> DATA_OE_N)
        else $error("data driven while idle");
    idle_chain_a: assert property (!active |=> CHAIN_ENABLE_OUT_N)
        else $error("chain low while idle");
    idle_counter_a: assert property (!active |=> (addr_q == '0) && !past_q)
        else $error("counter not reset while idle");
    handoff_edge_a: assert property (active && cfg_rise && !past_q && addr_q == LAST_ADDRESS
                                     |=> past_q && !CHAIN_ENABLE_OUT_N && DATA_OE_N)
        else $error("no hand-off after last item");
    count_step_a: assert property (active && cfg_rise && !past_q && addr_q != LAST_ADDRESS
                                   |=> addr_q == $past(addr_q) + ADDR_W'(1) && !DATA_OE_N)
        else $error("address did not step");
    no_edge_hold_a: assert property (active && !cfg_rise |=> $stable(addr_q))
        else $error("address moved without clock edge");
    past_hold_a: assert property (active && past_q ##1 active |-> $stable(addr_q) && !CHAIN_ENABLE_OUT_N)
        else $error("counter moved after end");
    drive_enable_a: assert property (active && !past_q && !cfg_rise |=> !DATA_OE_N && CHAIN_ENABLE_OUT_N)
        else $error("data not driven when enabled");
    por_hold_a: assert property (!por_done_q |=> !OE_RESET_OUT && (!OE_RESET_OE_N || por_done_q))
        else $error("reset line released early");
    por_release_a: assert property ($rose(por_done_q) |=> OE_RESET_OE_N)
        else $error("reset line held after power-up");

    hold_length_a: assert property ($rose(OE_RESET_OE_N) |-> hold_seen_q == POR_W'(POR_CYCLES))
        else $error("power-up hold has wrong length");
    hold_gate_a: assert property (!por_done_q |=> DATA_OE_N && CHAIN_ENABLE_OUT_N)
        else $error("readout during power-up hold");
    oer_value_a: assert property (OE_RESET_OUT == 1'b0)
        else $error("reset line driven high");
    exclusive_pins_a: assert property (DATA_OE_N || CHAIN_ENABLE_OUT_N)
        else $error("data driven while chain enable low");
    wrap_zero_a: assert property (active && cfg_rise && !past_q && addr_q == LAST_ADDRESS |=> addr_q == '0)
        else $error("counter did not wrap to zero");
    wire_low_reset_a: assert property (!OE_RESET_IN |=> addr_q == '0 && DATA_OE_N && CHAIN_ENABLE_OUT_N)
        else $error("reset line low did not reset");
    standby_float_a: assert property (CHIP_ENABLE_IN_N |=> addr_q == '0 && DATA_OE_N && CHAIN_ENABLE_OUT_N)
        else $error("standby did not reset");
    first_word_a: assert property (!active ##1 active |=> !DATA_OE_N)
        else $error("data not driven after enable");

    stream_c: cover property (active && cfg_rise && addr_q == ADDR_W'(1));
    handoff_c: cover property ($fell(CHAIN_ENABLE_OUT_N));
    abort_c: cover property (active && !past_q ##1 !active);
    por_c: cover property ($rose(por_done_q));
    standby_c: cover property (por_done_q && CHIP_ENABLE_IN_N && !OE_RESET_IN);

endmodule

// ### tb/fpga_cfg_model.sv
// Purpose: FPGA side of the serial configuration link
// Assumes: Data line carries a pull-up
// Notes:   Clock stands low between bursts
`timescale 1ns/10ps
module fpga_cfg_model (
    input  wire logic       clk,
    input  wire logic       din,
    output logic            cfg_clk,
    output logic      [7:0] got
);
    initial begin
        cfg_clk = 1'b0;
        got     = 8'h00;
    end
    // One bit taken at each own rising edge
    task automatic pulse(input int n);
        repeat (n) begin
            @(negedge clk);
            cfg_clk = 1'b1;
            got     = {got[6:0], din};
            @(negedge clk);
            cfg_clk = 1'b0;
        end
    endtask
endmodule

// ### tb/testbench.sv
// Purpose: Self-checking bench for the readout control
// Assumes: Four-word store, short power-up hold
// Notes:   Reset wire and data line resolved here
`timescale 1ns/10ps
module testbench;
    localparam int         POR   = 20;
    localparam logic [3:0] WORDS = 4'ha;
    logic       clk = 1'b0;
    logic       rst_n;
    logic       ce_n;
    logic       fpga_low = 1'b0;
    logic       ld;
    logic [1:0] ld_addr;
    logic [0:0] ld_data;
    logic       oer_out;
    logic       oer_oe_n;
    logic       oe_n;
    logic       chain_n;
    logic       cfg_clk;
    logic       oer_wire;
    logic       din;
    logic [0:0] dout;
    logic [7:0] got;
    int         n_mismatch = 0;
    int         check_count = 0;
    always #2.5 clk = ~clk;
    // Pull-ups on both shared wires
    assign oer_wire = (fpga_low || (!oer_oe_n && !oer_out)) ? 1'b0 : 1'b1;
    assign din      = oe_n ? 1'b1 : dout[0];
    prom_readout #(.DATA_W(1), .DEPTH(4), .POR_CYCLES(POR)) i_dut (
        .CORE_CLK(clk), .RST_N(rst_n), .CONFIG_CLOCK(cfg_clk), .CHIP_ENABLE_IN_N(ce_n),
        .OE_RESET_IN(oer_wire), .OE_RESET_OUT(oer_out), .OE_RESET_OE_N(oer_oe_n),
        .DATA_OUT(dout), .DATA_OE_N(oe_n), .CHAIN_ENABLE_OUT_N(chain_n),
        .LOAD_EN(ld), .LOAD_ADDR(ld_addr), .LOAD_DATA(ld_data));
    fpga_cfg_model i_fpga (.clk(clk), .din(din), .cfg_clk(cfg_clk), .got(got));
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic t_power_up();
        wait_n(1);
        check("oer_oe_n", 8'(oer_oe_n), 8'h00);
        wait_n(19);
        rst_n = 1'b1;
        wait_n(POR - 2);
        check("oer_wire", 8'(oer_wire), 8'h00);
        wait_n(4);
        check("oer_wire", 8'(oer_wire), 8'h01);
        check("oer_out", 8'(oer_out), 8'h00);
        check("oe_n", 8'(oe_n), 8'h01);
    endtask
    task automatic t_load();
        for (int i = 0; i < 4; i++) begin
            @(negedge clk);
            ld      = 1'b1;
            ld_addr = 2'(i);
            ld_data = WORDS[i];
        end
        @(negedge clk);
        ld = 1'b0;
    endtask
    task automatic t_readout();
        ce_n = 1'b0;
        wait_n(2);
        check("oe_n", 8'(oe_n), 8'h00);
        check("chain_n", 8'(chain_n), 8'h01);
        i_fpga.pulse(5);
        wait_n(2);
        // Fifth bit is the pull-up: data must float
        check("got", {3'h0, got[4:0]}, 8'h0b);
        check("oe_n", 8'(oe_n), 8'h01);
        check("chain_n", 8'(chain_n), 8'h00);
        i_fpga.pulse(2);
        check("chain_n", 8'(chain_n), 8'h00);
    endtask
    task automatic t_standby();
        ce_n = 1'b1;
        wait_n(2);
        check("oe_n", 8'(oe_n), 8'h01);
        check("chain_n", 8'(chain_n), 8'h01);
        fpga_low = 1'b1;
        wait_n(2);
        check("oe_n", 8'(oe_n), 8'h01);
        fpga_low = 1'b0;
        ce_n     = 1'b0;
        wait_n(2);
        check("dout", 8'(dout), 8'(WORDS[0]));
        check("din", 8'(din), 8'(WORDS[0]));
    endtask
    task automatic t_wire_low();
        i_fpga.pulse(3);
        check("got", {5'h0, got[2:0]}, 8'h02);
        fpga_low = 1'b1;
        wait_n(2);
        check("oe_n", 8'(oe_n), 8'h01);
        check("chain_n", 8'(chain_n), 8'h01);
        fpga_low = 1'b0;
        wait_n(2);
        i_fpga.pulse(1);
        check("got", {7'h0, got[0]}, 8'(WORDS[0]));
    endtask
    initial begin
        rst_n   = 1'b0;
        ce_n    = 1'b1;
        ld      = 1'b0;
        ld_addr = 2'h0;
        ld_data = 1'h0;
        t_power_up();
        t_load();
        t_readout();
        t_standby();
        t_wire_low();
        report_and_stop();
    end
    // Whole sequence needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end
endmodule
